// >>> rtl/rhp_pkg.sv
package rhp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [7:0] OFS_PORT = 8'h00;
   localparam logic [7:0] OFS_HUB = 8'h04;
   localparam logic [7:0] OFS_INT_STAT = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0c;
   // port register fields
   localparam int B_CONNECT = 0;
   localparam int B_SET_RESET = 4;
   localparam int B_SET_POWER = 8;
   localparam int B_CLR_POWER = 9;
   localparam int B_CONN_CHG = 16;
   localparam int B_RST_DONE = 20;
   // hub word global power commands
   localparam int B_GLB_CLR = 0;
   localparam int B_GLB_SET = 16;
   // interrupt status / mask layout
   localparam int IRQ_W = 3;
   localparam int I_CONN = 0;
   localparam int I_RST_DONE = 1;
   localparam int I_OVER_CUR = 2;
   localparam logic [IRQ_W-1:0] INT_MASK_RST = 3'h0;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // port reset signalling time
   localparam int CLK_KHZ = 25000;
   localparam int RESET_TIME_MS = 10;
   localparam int RESET_CYCLES = RESET_TIME_MS * CLK_KHZ;

   typedef enum logic [1:0] {
      RST_IDLE = 2'b01,
      RST_DRIVE = 2'b10
   } rhp_rst_state_t;

   // live state of the port from the rest of the port logic
   typedef struct packed {
      logic connected;
      logic slow_device;
      logic over_current;
   } rhp_port_in_t;

   // hub descriptor power switching setup
   typedef struct packed {
      logic per_port_mode;
      logic port_mask;
   } rhp_pwr_cfg_t;
endpackage

// >>> rtl/rhp_port_ctl.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Function
// - unused bits 15:10 and 7:5 read zero, writes to them ignored
// - bit 9 reads one for low speed device, zero for full speed
// - speed bit is only meaningful while connect status is set
// - writing one to bit 9 clears port power status
// - over-current condition clears port power status
// - power set by bit 8 write or global set command at hub bit 16
// - power cleared by per-port clear or global clear at hub bit 0
// - global switching mode: only global commands change port power
// - per-port mode with mask set: only per-port commands act
// - per-port mode with mask clear: only global commands act
// - removing port power clears reset status and pulses power_off_clear for one cycle
// - writing one to bit 4 starts reset, signalling while status set
// - reset end clears reset status and sets bit 20 together
// - reset write while disconnected leaves reset, sets connect change
// - writing zero to bits 9, 8 or 4 changes nothing
// - reset-done flag set after 10 ms reset, cleared by writing one
// - connect change set on each connect event, cleared by writing one
module rhp_port_ctl
   import rhp_pkg::*;
#(
   parameter int RESET_CYC = RESET_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire rhp_pkg::rhp_port_in_t port_in,
   input wire rhp_pkg::rhp_pwr_cfg_t pwr_cfg,
   output logic port_power_on,
   output logic port_reset_active,
   output logic power_off_clear,
   output logic irq
);
   import rhp_pkg::*;

   localparam int CNT_W = $clog2(RESET_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RESET_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   function automatic logic [DATA_W-1:0] lane_mask(
      input logic [DATA_W/8-1:0] strb
   );
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < DATA_W/8; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // sticky flag: hardware set wins over a software clear
   function automatic logic sticky(
      input logic cur,
      input logic clr,
      input logic set
   );
      return (cur & ~clr) | set;
   endfunction

   function automatic logic known_addr(input logic [ADDR_W-1:0] a);
      return a == OFS_PORT || a == OFS_HUB ||
         a == OFS_INT_STAT || a == OFS_INT_MASK;
   endfunction

   // bus slave state
   logic aw_full_reg, aw_full_next;
   logic w_full_reg, w_full_next;
   logic [ADDR_W-1:0] waddr_reg, waddr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;

   // port state
   logic power_reg, power_next;
   rhp_rst_state_t rst_st_reg, rst_st_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic conn_chg_reg, conn_chg_next;
   logic rst_done_reg, rst_done_next;
   logic conn_prev_reg, conn_prev_next;
   logic pwr_clr_reg, pwr_clr_next;
   logic [IRQ_W-1:0] int_stat_reg, int_stat_next;
   logic [IRQ_W-1:0] int_mask_reg, int_mask_next;
   logic irq_reg, irq_next;

   // decoded write strobes of the committing write
   logic wr_go;
   logic [DATA_W-1:0] wd;
   logic wr_port, wr_hub, wr_stat, wr_mask;
   logic per_port_en;
   logic pwr_set, pwr_clr;
   logic rst_req, rst_reject, rst_end;
   logic conn_evt, oc_drop;
   logic [IRQ_W-1:0] evt;

   always_comb begin
      // write commits once both halves are held and no answer pends
      wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
      wd = wdata_reg;
      wr_port = wr_go & (waddr_reg == OFS_PORT);
      wr_hub = wr_go & (waddr_reg == OFS_HUB);
      wr_stat = wr_go & (waddr_reg == OFS_INT_STAT);
      wr_mask = wr_go & (waddr_reg == OFS_INT_MASK);

      // mode and mask are taken live in the command cycle
      per_port_en = pwr_cfg.per_port_mode & pwr_cfg.port_mask;
      pwr_set = per_port_en ?
         (wr_port & wd[B_SET_POWER]) :
         (wr_hub & wd[B_GLB_SET]);
      pwr_clr = per_port_en ?
         (wr_port & wd[B_CLR_POWER]) :
         (wr_hub & wd[B_GLB_CLR]);

      // zero in a command bit simply yields no request
      rst_req = wr_port & wd[B_SET_RESET];
      rst_reject = rst_req & ~port_in.connected;
      rst_end = (rst_st_reg == RST_DRIVE) && (cnt_reg == CNT_ZERO);

      conn_evt = port_in.connected != conn_prev_reg;
      oc_drop = port_in.over_current & power_reg;

      // power: over-current and clear both beat set
      power_next = power_reg;
      if (port_in.over_current || pwr_clr) begin
         power_next = 1'b0;
      end else if (pwr_set) begin
         power_next = 1'b1;
      end
      // one-cycle notice so the rest of the port drops its state
      pwr_clr_next = power_reg & ~power_next;

      // reset sequencer
      rst_st_next = rst_st_reg;
      cnt_next = cnt_reg;
      case (rst_st_reg)
         RST_IDLE: begin
            if (rst_req && port_in.connected) begin
               rst_st_next = RST_DRIVE;
               cnt_next = CNT_LOAD;
            end
         end
         RST_DRIVE: begin
            if (rst_end) begin
               rst_st_next = RST_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            rst_st_next = RST_IDLE;
            cnt_next = CNT_ZERO;
         end
      endcase
      // power loss aborts a reset in progress without completing it
      if (!power_next) begin
         rst_st_next = RST_IDLE;
         cnt_next = CNT_ZERO;
      end

      // change flags, write one to clear, set wins
      conn_chg_next = sticky(conn_chg_reg,
         wr_port & wd[B_CONN_CHG],
         conn_evt | rst_reject);
      rst_done_next = sticky(rst_done_reg,
         wr_port & wd[B_RST_DONE],
         rst_end & power_next);
      conn_prev_next = port_in.connected;

      // interrupt status and mask
      evt = '0;
      evt[I_CONN] = conn_evt | rst_reject;
      evt[I_RST_DONE] = rst_end & power_next;
      evt[I_OVER_CUR] = oc_drop;
      int_stat_next = int_stat_reg;
      for (int i = 0; i < IRQ_W; i++) begin
         int_stat_next[i] = sticky(int_stat_reg[i],
            wr_stat & wd[i], evt[i]);
      end
      int_mask_next = wr_mask ? wd[IRQ_W-1:0] : int_mask_reg;
      irq_next = |(int_stat_next & int_mask_next);
   end

   always_comb begin
      // write address and data channels, either order
      aw_full_next = aw_full_reg;
      w_full_next = w_full_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_full_next = 1'b1;
         waddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_full_next = 1'b1;
         // masked lanes become zero, so they issue no command
         wdata_next = s_axi_wdata & lane_mask(s_axi_wstrb);
      end
      if (wr_go) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = known_addr(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      awready_next = ~aw_full_next;
      wready_next = ~w_full_next;

      // read channel, one outstanding read
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_arvalid && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = '0;
         case (s_axi_araddr)
            OFS_PORT: begin
               rdata_next[B_CONNECT] = port_in.connected;
               rdata_next[B_SET_RESET] = rst_st_reg == RST_DRIVE;
               rdata_next[B_SET_POWER] = power_reg;
               // raw speed; software checks bit 0 first
               rdata_next[B_CLR_POWER] = port_in.slow_device;
               rdata_next[B_CONN_CHG] = conn_chg_reg;
               rdata_next[B_RST_DONE] = rst_done_reg;
            end
            OFS_HUB: begin
               rdata_next = '0;
            end
            OFS_INT_STAT: begin
               rdata_next[IRQ_W-1:0] = int_stat_reg;
            end
            OFS_INT_MASK: begin
               rdata_next[IRQ_W-1:0] = int_mask_reg;
            end
            default: begin
               rresp_next = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= '0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         // ready rises one cycle after reset is released
         arready_reg <= arready_next | (~arready_reg & ~rvalid_reg);
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         power_reg <= 1'b0;
         rst_st_reg <= RST_IDLE;
         cnt_reg <= CNT_ZERO;
         conn_chg_reg <= 1'b0;
         rst_done_reg <= 1'b0;
         conn_prev_reg <= 1'b0;
         pwr_clr_reg <= 1'b0;
         int_stat_reg <= '0;
         int_mask_reg <= INT_MASK_RST;
         irq_reg <= 1'b0;
      end else begin
         power_reg <= power_next;
         rst_st_reg <= rst_st_next;
         cnt_reg <= cnt_next;
         conn_chg_reg <= conn_chg_next;
         rst_done_reg <= rst_done_next;
         conn_prev_reg <= conn_prev_next;
         pwr_clr_reg <= pwr_clr_next;
         int_stat_reg <= int_stat_next;
         int_mask_reg <= int_mask_next;
         irq_reg <= irq_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign port_power_on = power_reg;
   // reset signalling is driven for exactly the state's lifetime
   assign port_reset_active = rst_st_reg[1];
   assign power_off_clear = pwr_clr_reg;
   assign irq = irq_reg;
endmodule

// >>> testbench/rhp_port_ctl_props.sv
`timescale 1ns/1ns
module rhp_port_ctl_props
   import rhp_pkg::*;
#(
   parameter int RESET_CYC = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire rhp_pkg::rhp_port_in_t port_in,
   input wire logic port_power_on,
   input wire logic port_reset_active,
   input wire logic power_off_clear
);
   logic port_rd_reg;
   logic port_rd_next;
   int cnt_reg;
   int cnt_next;
   always_comb begin
      port_rd_next = port_rd_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         port_rd_next = (s_axi_araddr == OFS_PORT);
      end
      cnt_next = port_reset_active ? cnt_reg + 1 : 0;
   end
   always_ff @(posedge clk) begin
      port_rd_reg <= rst ? 1'b0 : port_rd_next;
      cnt_reg <= rst ? 0 : cnt_next;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   over_cur_off_a: assert property (port_in.over_current |=> !port_power_on)
      else $error("power stayed on through over-current");
   read_fields_a: assert property ($rose(s_axi_rvalid) && port_rd_reg |->
      s_axi_rdata[9] == $past(port_in.slow_device) &&
      s_axi_rdata[8] == $past(port_power_on) &&
      s_axi_rdata[4] == $past(port_reset_active))
      else $error("port read fields wrong");
   rsvd_zero_a: assert property (s_axi_rvalid |->
      s_axi_rdata[15:10] == 6'h00 && s_axi_rdata[7:5] == 3'h0)
      else $error("unused bits not zero");
   reset_len_a: assert property (port_reset_active |-> cnt_reg < RESET_CYC)
      else $error("reset signalling too long");
   reset_end_a: assert property ($fell(port_reset_active) && port_power_on
      |-> cnt_reg == RESET_CYC)
      else $error("reset signalling ended early");
   reset_power_a: assert property ($fell(port_power_on) |=> !port_reset_active)
      else $error("reset kept after power loss");
   off_pulse_a: assert property (power_off_clear |->
      !port_power_on ##1 !power_off_clear)
      else $error("power off pulse wrong");
   ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   cover property ($fell(port_reset_active) && port_power_on);
   cover property (power_off_clear);
   cover property ($rose(s_axi_rvalid) && port_rd_reg);
endmodule
bind rhp_port_ctl rhp_port_ctl_props #(.RESET_CYC(RESET_CYC)) i_props (
   .clk(clk), .rst(rst), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .port_in(port_in), .port_power_on(port_power_on),
   .port_reset_active(port_reset_active), .power_off_clear(power_off_clear));

// >>> testbench/rhp_dev_model.sv
`timescale 1ns/1ns
module rhp_dev_model
   import rhp_pkg::*;
(
   input wire logic clk,
   input wire logic attach,
   input wire logic low_speed,
   input wire logic fault,
   output rhp_pkg::rhp_port_in_t port_in = '0
);
   logic idle_reg = 1'b0;
   always @(posedge clk) begin
      idle_reg <= ~idle_reg;
      port_in.connected <= attach;
      // no device, no speed: keep the line moving so nothing relies on it
      port_in.slow_device <= attach ? low_speed : ~idle_reg;
      port_in.over_current <= fault;
   end
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import rhp_pkg::*;
   localparam int RC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic attach = 1'b0;
   logic low_speed = 1'b0;
   logic fault = 1'b0;
   logic [3:0] strb = 4'hf;
   rhp_pwr_cfg_t cfg = '0;
   rhp_port_in_t port_in;
   logic awready, wready, bvalid, arready, rvalid, pwr, rst_act, irq;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rv;
   logic [1:0] modes [3] = '{2'b00, 2'b11, 2'b10};
   logic pp;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   rhp_port_ctl #(.RESET_CYC(RC)) i_rhp_port_ctl (.clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .port_in(port_in), .pwr_cfg(cfg),
      .port_power_on(pwr), .port_reset_active(rst_act),
      .power_off_clear(), .irq(irq));
   rhp_dev_model i_rhp_dev_model (.clk(clk), .attach(attach),
      .low_speed(low_speed), .fault(fault), .port_in(port_in));
   task end_sim;
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rv = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // a hang in any handshake ends here rather than running forever
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_sim;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // speed bit is noise while nothing is attached, so it is masked
      rd(OFS_PORT); chk(rv & ~32'h200, 32'h0);
      wr(OFS_PORT, 32'h10); rd(OFS_PORT); chk(rv & ~32'h200, 32'h10000);
      wr(OFS_PORT, 32'h10000); rd(OFS_PORT); chk(rv & ~32'h200, 32'h0);
      $display("test disconnected done");
      for (int m = 0; m < 3; m++) begin
         cfg <= modes[m];
         pp = (modes[m] == 2'b11);
         wr(OFS_HUB, pp ? 32'h10000 : 32'h0); chk(32'(pwr), 32'h0);
         wr(OFS_PORT, 32'h100); chk(32'(pwr), 32'(pp));
         wr(OFS_HUB, 32'h10000); chk(32'(pwr), 32'h1);
         wr(OFS_PORT, 32'h0); chk(32'(pwr), 32'h1);
         wr(OFS_PORT, 32'h200); chk(32'(pwr), 32'(!pp));
         wr(OFS_HUB, 32'h1); chk(32'(pwr), 32'h0);
         wr(pp ? OFS_PORT : OFS_HUB, pp ? 32'h300 : 32'h10001);
         chk(32'(pwr), 32'h0);
      end
      $display("test power modes done");
      cfg <= 2'b00;
      wr(OFS_HUB, 32'h10000);
      attach <= 1'b1;
      low_speed <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFS_PORT); chk(rv, 32'h10301);
      wr(OFS_PORT, 32'h10000);
      wr(OFS_PORT, 32'h10); rd(OFS_PORT); chk(rv, 32'h311);
      chk(32'(rst_act), 32'h1);
      repeat (RC) @(posedge clk);
      rd(OFS_PORT); chk(rv, 32'h100301);
      chk(32'(rst_act), 32'h0);
      wr(OFS_PORT, 32'h100000); rd(OFS_PORT); chk(rv, 32'h301);
      $display("test port reset done");
      wr(OFS_PORT, 32'h10);
      fault <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFS_PORT); chk(rv, 32'h201);
      wr(OFS_HUB, 32'h10000); chk(32'(pwr), 32'h0);
      rd(OFS_INT_STAT); chk(rv, 32'h7);
      chk(32'(irq), 32'h0);
      wr(OFS_INT_MASK, 32'h4);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      fault <= 1'b0;
      wr(OFS_INT_STAT, 32'h4);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      rd(OFS_INT_STAT); chk(rv, 32'h3);
      $display("test over-current and interrupt done");
      rd(8'h40); chk(rv, 32'h0);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(8'h40, 32'hffffffff); chk(32'(resp), 32'(RESP_SLVERR));
      attach <= 1'b0;
      repeat (3) @(posedge clk);
      rd(OFS_PORT); chk(rv & ~32'h200, 32'h10000);
      // lane 2 switched off: the clear bit never reaches the flag
      strb <= 4'hb;
      wr(OFS_PORT, 32'h10000);
      strb <= 4'hf;
      rd(OFS_PORT); chk(rv & ~32'h200, 32'h10000);
      $display("test unmapped and detach done");
      end_sim;
   end
endmodule
